/* File: common/rwpf_pkg.sv */
package rwpf_pkg;

   // ************************************************************
   // Filter control fields
   // ************************************************************
   localparam int unsigned RWPF_CTL_HASH_EN = 15;
   localparam int unsigned RWPF_CTL_WAKE_EN = 14;
   localparam int unsigned RWPF_CTL_INVERT = 12;
   localparam int unsigned RWPF_CTL_MODE_HI = 11;
   localparam int unsigned RWPF_CTL_MODE_LO = 8;
   localparam int unsigned RWPF_CTL_CRC_EN = 6;
   localparam int unsigned RWPF_CTL_RUNT_EN = 4;
   localparam int unsigned RWPF_CTL_UCAST_EN = 3;
   localparam int unsigned RWPF_CTL_OTHER_EN = 2;
   localparam int unsigned RWPF_CTL_GROUP_EN = 1;
   localparam int unsigned RWPF_CTL_BCAST_EN = 0;
   localparam int unsigned RWPF_MAC1_PASS_ALL = 1;

   // ************************************************************
   // Pattern filter modes
   // ************************************************************
   localparam logic [3:0] RWPF_MODE_PATTERN = 4'h1;
   localparam logic [3:0] RWPF_MODE_OWN = 4'h2;
   localparam logic [3:0] RWPF_MODE_OTHER = 4'h3;
   localparam logic [3:0] RWPF_MODE_GROUP = 4'h4;
   localparam logic [3:0] RWPF_MODE_BCAST = 4'h5;
   localparam logic [3:0] RWPF_MODE_HASH = 4'h6;
   localparam logic [3:0] RWPF_MODE_WAKE = 4'h7;

   // ************************************************************
   // Sizes, counts and reset values
   // ************************************************************
   localparam logic [15:0] RWPF_WIN_BYTES = 16'h0040;
   localparam logic [15:0] RWPF_MIN_FRAME = 16'h0040;
   localparam logic [15:0] RWPF_ADDR_BYTES = 16'h0006;
   localparam logic [2:0] RWPF_SYNC_BYTES = 3'h6;
   localparam logic [6:0] RWPF_WAKE_LAST = 7'h5f;
   localparam logic [7:0] RWPF_CNT_RESET = 8'h00;
   localparam logic [7:0] RWPF_CNT_MAX = 8'hff;
   localparam logic [47:0] RWPF_BCAST_ADDR = 48'hffff_ffff_ffff;
   localparam logic [31:0] RWPF_CRC_POLY = 32'h04c1_1db7;
   localparam logic [31:0] RWPF_CRC_INIT = 32'hffff_ffff;
   localparam int unsigned RWPF_HASH_HI = 28;
   localparam int unsigned RWPF_HASH_LO = 23;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      RWPF_ST_IDLE = 3'b001,
      RWPF_ST_RECV = 3'b010,
      RWPF_ST_DECIDE = 3'b100
   } rwpf_state_e;

   typedef struct packed {
      logic valid;
      logic first;
      logic last;
      logic crc_ok;
      logic [7:0] data;
   } rwpf_byte_s;

   typedef struct packed {
      logic accept;
      logic discard;
   } rwpf_verdict_s;

   // ************************************************************
   // Arithmetic
   // ************************************************************
   // Ones-complement add with end-around carry
   function automatic logic [15:0] rwpf_ones_add(logic [15:0] a,
                                                logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : rwpf_ones_add

   // CRC-32 over one byte, least significant bit first
   function automatic logic [31:0] rwpf_crc_byte(logic [31:0] c,
                                                logic [7:0] d);
      logic fb;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         fb = c[31] ^ d[i];
         c = {c[30:0], 1'b0} ^ (fb ? RWPF_CRC_POLY : 32'h0000_0000);
      end
      return c;
   endfunction : rwpf_crc_byte

endpackage : rwpf_pkg

/* File: rtl/rwpf_wakeup_det.sv */
`timescale 1ns/1ps
module rwpf_wakeup_det (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Received byte stream
   input wire rwpf_pkg::rwpf_byte_s rx_byte,
   // Station address, first byte in bits 47:40
   input wire logic [47:0] local_station_address,
   // Pattern seen in the current frame
   output logic found_q
);
   import rwpf_pkg::*;

   logic [2:0] ff_run_q, ff_run_d;
   logic [6:0] pos_q, pos_d;
   logic found_d;
   logic [2:0] run_base;
   logic [6:0] pos_base;
   logic [7:0] exp_byte;
   logic [2:0] sel;

   // ************************************************************
   // Scanner next state
   // ************************************************************
   always_comb begin
      run_base = rx_byte.first ? 3'h0 : ff_run_q;
      pos_base = rx_byte.first ? 7'h00 : pos_q;
      ff_run_d = ff_run_q;
      pos_d = pos_q;
      found_d = rx_byte.first ? 1'b0 : found_q;
      sel = 3'(pos_base % 7'h06);
      exp_byte = local_station_address[8'(47 - 8 * sel) -: 8];
      if (rx_byte.valid) begin
         ff_run_d = (rx_byte.data == 8'hff) ?
            ((run_base == RWPF_SYNC_BYTES) ? run_base : run_base + 3'h1)
            : 3'h0;
         if (pos_base != 7'h00 && rx_byte.data == exp_byte) begin
            pos_d = pos_base + 7'h01;
         end else if (run_base == RWPF_SYNC_BYTES &&
                      rx_byte.data == local_station_address[47:40]) begin
            pos_d = 7'h01;
         end else begin
            pos_d = 7'h00;
         end
         if (pos_base == RWPF_WAKE_LAST && rx_byte.data == exp_byte) begin
            found_d = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ff_run_q <= 3'h0;
         pos_q <= 7'h00;
         found_q <= 1'b0;
      end else begin
         ff_run_q <= ff_run_d;
         pos_q <= pos_d;
         found_q <= found_d;
      end
   end

endmodule : rwpf_wakeup_det

/* File: rtl/rwpf_top.sv */
`timescale 1ns/1ps
module rwpf_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Receive byte stream from the MAC
   input wire rwpf_pkg::rwpf_byte_s rx_byte,
   // Filter configuration
   input wire logic [15:0] rx_filter_control,
   input wire logic [15:0] mac_control_one,
   input wire logic [15:0] pattern_window_offset,
   input wire logic [63:0] pattern_byte_mask,
   input wire logic [15:0] pattern_expected_checksum,
   input wire logic [63:0] hash_table,
   input wire logic [47:0] local_station_address,
   // Receive buffer state
   input wire logic [15:0] rx_buffer_free,
   input wire logic packet_consumed,
   // Results
   output rwpf_pkg::rwpf_verdict_s verdict_q,
   output logic [7:0] pending_packet_count_q
);
   import rwpf_pkg::*;

   rwpf_state_e state_q, state_d;
   logic [15:0] len_q, len_d;
   logic [47:0] da_q, da_d;
   logic [31:0] crc_q, crc_d;
   logic [15:0] sum_q, sum_d;
   logic [7:0] hi_q, hi_d;
   logic hi_pend_q, hi_pend_d;
   logic crc_ok_q, crc_ok_d;
   rwpf_verdict_s verdict_d;
   logic [7:0] pending_packet_count_d;
   logic wake_found;

   logic [15:0] idx, len_base, sum_base, off, rel;
   logic hi_pend_base, in_win;
   logic [47:0] da_base;
   logic [31:0] crc_base;

   logic [15:0] final_sum, csum;
   logic [3:0] mode;
   logic pass_all, pat_res, pat_ok, win_full;
   logic own, group, bcast, other, hash_hit, rej, acc;

   // ************************************************************
   // Wake-up scanner
   // ************************************************************
   rwpf_wakeup_det u_wake (
      .clk(clk),
      .rst_b(rst_b),
      .rx_byte(rx_byte),
      .local_station_address(local_station_address),
      .found_q(wake_found)
   );

   // ************************************************************
   // Per-byte collection
   // ************************************************************
   always_comb begin
      len_base = rx_byte.first ? 16'h0000 : len_q;
      da_base = rx_byte.first ? 48'h0 : da_q;
      crc_base = rx_byte.first ? RWPF_CRC_INIT : crc_q;
      sum_base = rx_byte.first ? 16'h0000 : sum_q;
      hi_pend_base = rx_byte.first ? 1'b0 : hi_pend_q;
      idx = len_base;
      // offset counts from DA byte zero
      off = {10'h000, pattern_window_offset[5:0]};
      rel = idx - off;
      in_win = (idx >= off) && (idx < off + RWPF_WIN_BYTES);
      state_d = state_q;
      len_d = len_q;
      da_d = da_q;
      crc_d = crc_q;
      sum_d = sum_q;
      hi_d = hi_q;
      hi_pend_d = hi_pend_q;
      crc_ok_d = crc_ok_q;
      if (state_q == RWPF_ST_DECIDE) begin
         state_d = RWPF_ST_IDLE;
      end
      if (rx_byte.valid && (rx_byte.first || state_q == RWPF_ST_RECV)) begin
         state_d = rx_byte.last ? RWPF_ST_DECIDE : RWPF_ST_RECV;
         len_d = (len_base == 16'hffff) ? len_base : len_base + 16'h0001;
         da_d = da_base;
         crc_d = crc_base;
         sum_d = sum_base;
         hi_pend_d = hi_pend_base;
         crc_ok_d = rx_byte.crc_ok;
         if (idx < RWPF_ADDR_BYTES) begin
            da_d = {da_base[39:0], rx_byte.data};
            crc_d = rwpf_crc_byte(crc_base, rx_byte.data);
         end
         if (in_win && pattern_byte_mask[rel[5:0]]) begin
            if (!hi_pend_base) begin
               hi_d = rx_byte.data;
               hi_pend_d = 1'b1;
            end else begin
               sum_d = rwpf_ones_add(sum_base, {hi_q, rx_byte.data});
               hi_pend_d = 1'b0;
            end
         end
      end
   end

   // Collection registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= RWPF_ST_IDLE;
         len_q <= 16'h0000;
         da_q <= 48'h0;
         crc_q <= RWPF_CRC_INIT;
         sum_q <= 16'h0000;
         hi_q <= 8'h00;
         hi_pend_q <= 1'b0;
         crc_ok_q <= 1'b0;
      end else begin
         state_q <= state_d;
         len_q <= len_d;
         da_q <= da_d;
         crc_q <= crc_d;
         sum_q <= sum_d;
         hi_q <= hi_d;
         hi_pend_q <= hi_pend_d;
         crc_ok_q <= crc_ok_d;
      end
   end

   // ************************************************************
   // Frame decision
   // ************************************************************
   always_comb begin
      mode = rx_filter_control[RWPF_CTL_MODE_HI:RWPF_CTL_MODE_LO];
      pass_all = mac_control_one[RWPF_MAC1_PASS_ALL];
      final_sum = hi_pend_q ? rwpf_ones_add(sum_q, {hi_q, 8'h00}) : sum_q;
      csum = ~final_sum;
      win_full = len_q >= off + RWPF_WIN_BYTES;
      pat_res = ((csum == pattern_expected_checksum) ^
                 rx_filter_control[RWPF_CTL_INVERT]) && win_full;
      own = da_q == local_station_address;
      group = da_q[40];
      bcast = da_q == RWPF_BCAST_ADDR;
      other = !group && !own;
      hash_hit = hash_table[crc_q[RWPF_HASH_HI:RWPF_HASH_LO]];
      case (mode)
         RWPF_MODE_PATTERN: pat_ok = pat_res;
         RWPF_MODE_OWN: pat_ok = pat_res && own;
         RWPF_MODE_OTHER: pat_ok = pat_res && other;
         RWPF_MODE_GROUP: pat_ok = pat_res && group;
         RWPF_MODE_BCAST: pat_ok = pat_res && bcast;
         RWPF_MODE_HASH: pat_ok = pat_res && hash_hit;
         RWPF_MODE_WAKE: pat_ok = pat_res && wake_found;
         default: pat_ok = 1'b0;
      endcase
      rej = (len_q > rx_buffer_free) ||
            (pending_packet_count_q == RWPF_CNT_MAX);
      rej = rej || (rx_filter_control[RWPF_CTL_CRC_EN] && !pass_all &&
                    !crc_ok_q);
      rej = rej || (rx_filter_control[RWPF_CTL_RUNT_EN] && !pass_all &&
                    len_q < RWPF_MIN_FRAME);
      acc = (rx_filter_control[RWPF_CTL_UCAST_EN] && own) ||
            (rx_filter_control[RWPF_CTL_OTHER_EN] && other) ||
            (rx_filter_control[RWPF_CTL_GROUP_EN] && group) ||
            (rx_filter_control[RWPF_CTL_BCAST_EN] && bcast) ||
            (rx_filter_control[RWPF_CTL_HASH_EN] && hash_hit);
      acc = acc || (rx_filter_control[RWPF_CTL_WAKE_EN] && wake_found);
      acc = !rej && (acc || pat_ok);
      verdict_d = '0;
      pending_packet_count_d = pending_packet_count_q;
      if (state_q == RWPF_ST_DECIDE) begin
         verdict_d.accept = acc;
         verdict_d.discard = !acc;
      end
      if (verdict_d.accept) begin
         pending_packet_count_d = pending_packet_count_d + 8'h01;
      end
      if (packet_consumed && pending_packet_count_q != RWPF_CNT_RESET) begin
         pending_packet_count_d = pending_packet_count_d - 8'h01;
      end
   end

   // Decision registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         verdict_q <= '0;
         pending_packet_count_q <= RWPF_CNT_RESET;
      end else begin
         verdict_q <= verdict_d;
         pending_packet_count_q <= pending_packet_count_d;
      end
   end

endmodule : rwpf_top

/* File: test/rwpf_link_model.sv */
`timescale 1ns/1ps
// ****
// Link partner: hands frames to the filter one byte a cycle
// ****
module rwpf_link_model (
   // Clock
   input wire logic clk,
   // Byte stream towards the filter
   output rwpf_pkg::rwpf_byte_s rx_byte
);
   import rwpf_pkg::*;
   logic [7:0] frm [0:255];

   // Idle line at start
   initial begin
      rx_byte = '0;
   end

   // Sends frm[0..len-1] back to back, FCS status on every byte
   task automatic send(input int len, input logic crc);
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         rx_byte <= '{1'b1, i == 0, i == len - 1, crc, frm[i]};
      end
      @(posedge clk);
      // Released data shows the inverse, never the last byte
      rx_byte <= '{1'b0, 1'b0, 1'b0, 1'b0, ~frm[len - 1]};
   endtask : send
endmodule : rwpf_link_model

/* File: test/rwpf_top_properties.sv */
`timescale 1ns/1ps
module rwpf_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Watched inputs
   input wire rwpf_pkg::rwpf_byte_s rx_byte,
   input wire logic [15:0] rx_filter_control,
   input wire logic [15:0] rx_buffer_free,
   input wire logic packet_consumed,
   // Watched outputs
   input wire rwpf_pkg::rwpf_verdict_s verdict_q,
   input wire logic [7:0] pending_packet_count_q
);
   import rwpf_pkg::*;
   logic in_frame_q;
   logic in_frame_d;
   logic end_now;
   logic any_v;
   logic [15:0] fc;

   // Frame open tracking and verdict summary
   always_comb begin
      fc = rx_filter_control;
      end_now = rx_byte.valid && rx_byte.last &&
                (rx_byte.first || in_frame_q);
      any_v = verdict_q.accept || verdict_q.discard;
      in_frame_d = (in_frame_q || (rx_byte.valid && rx_byte.first)) &&
                   !end_now && rst_b;
   end

   // Registers frame state
   always_ff @(posedge clk) begin
      in_frame_q <= in_frame_d;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   one_verdict_a: assert property (
      !(verdict_q.accept && verdict_q.discard))
      else $error("accept and discard together");
   verdict_latency_a: assert property (
      end_now |-> ##2 any_v)
      else $error("no verdict two cycles after frame end");
   no_stray_a: assert property (
      any_v |-> $past(end_now, 2))
      else $error("verdict without a frame end");
   count_up_a: assert property (
      verdict_q.accept && !$past(packet_consumed)
      |-> pending_packet_count_q == $past(pending_packet_count_q) + 8'h01)
      else $error("count not raised on accept");
   count_hold_a: assert property (
      verdict_q.discard && !$past(packet_consumed)
      |-> $stable(pending_packet_count_q))
      else $error("count moved on discard");
   count_down_a: assert property (
      $past(packet_consumed) && !verdict_q.accept
      |-> pending_packet_count_q ==
      ($past(pending_packet_count_q) == 8'h00 ? 8'h00 :
       $past(pending_packet_count_q) - 8'h01))
      else $error("count not lowered on consume");
   full_count_a: assert property (
      end_now ##1 pending_packet_count_q == 8'hff |=> verdict_q.discard)
      else $error("frame kept with full count");
   no_room_a: assert property (
      end_now ##1 rx_buffer_free == 16'h0000 |=> verdict_q.discard)
      else $error("frame kept without room");
   quiet_filters_a: assert property (
      verdict_q.accept |-> (|fc[15:14]) || (|fc[3:0]) ||
      (fc[11:8] inside {[4'h1:4'h7]}))
      else $error("accept with all filters off");

   cover property (verdict_q.accept);
   cover property (verdict_q.discard && pending_packet_count_q == 8'hff);
   cover property (packet_consumed && pending_packet_count_q != 8'h00);
endmodule : rwpf_chk

bind rwpf_top rwpf_chk chk_i (.clk(clk), .rst_b(rst_b), .rx_byte(rx_byte),
   .rx_filter_control(rx_filter_control), .rx_buffer_free(rx_buffer_free),
   .packet_consumed(packet_consumed), .verdict_q(verdict_q),
   .pending_packet_count_q(pending_packet_count_q));

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
   import rwpf_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   rwpf_byte_s rx_byte;
   logic [15:0] ctl = 16'h0000;
   logic [15:0] mac1 = 16'h0000;
   logic [15:0] offs = 16'h0000;
   logic [15:0] ecs = 16'h0000;
   logic [15:0] free = 16'hffff;
   logic [63:0] mask = 64'h0;
   logic [63:0] ht = 64'h0;
   logic [47:0] sta = 48'h0204_a3ff_ff01;
   logic cons = 1'b0;
   logic [7:0] exp_cnt = 8'h00;
   rwpf_verdict_s verdict_q;
   logic [7:0] pending_packet_count_q;
   int err_count = 0;
   int comparisons = 0;

   // Filter and partner
   rwpf_top dut (.clk(clk), .rst_b(rst_b), .rx_byte(rx_byte),
      .rx_filter_control(ctl), .mac_control_one(mac1),
      .pattern_window_offset(offs), .pattern_byte_mask(mask),
      .pattern_expected_checksum(ecs), .hash_table(ht),
      .local_station_address(sta), .rx_buffer_free(free),
      .packet_consumed(cons), .verdict_q(verdict_q),
      .pending_packet_count_q(pending_packet_count_q));
   rwpf_link_model link (.clk(clk), .rx_byte(rx_byte));

   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic results;
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // Reference checksum: skipped bytes vanish, words big-endian
   function automatic logic [15:0] csum(input int off, input logic [63:0] m);
      logic [31:0] s;
      int n;
      s = 32'h0;
      n = 0;
      for (int k = 0; k < 64; k++) begin
         if (m[k]) begin
            s = s + (n % 2 ? {24'h0, link.frm[off + k]} :
                     {16'h0, link.frm[off + k], 8'h00});
            n++;
         end
      end
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      return ~s[15:0];
   endfunction : csum

   task automatic build(input logic [47:0] da);
      for (int i = 0; i < 256; i++) begin
         link.frm[i] = 8'(i * 7 + 3);
      end
      for (int j = 0; j < 6; j++) begin
         link.frm[j] = da[47 - 8 * j -: 8];
      end
   endtask : build

   // Sends a frame and checks verdict and pending count
   task automatic run(input int len, input logic crc, input logic acc);
      int n;
      n = 0;
      link.send(len, crc);
      while (verdict_q === 2'b00 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (acc) begin
         exp_cnt++;
      end
      chk({6'h0, verdict_q, pending_packet_count_q}, {6'h0, acc, !acc, exp_cnt});
   endtask : run

   task automatic t_wake;
      build(48'h0a0b_0c0d_0e0f);
      for (int i = 20; i < 26; i++) begin
         link.frm[i] = 8'hff;
      end
      for (int i = 0; i < 96; i++) begin
         link.frm[26 + i] = sta[47 - 8 * (i % 6) -: 8];
      end
      run(130, 1'b1, 1'b0);
      @(posedge clk);
      ctl <= 16'h4000;
      run(130, 1'b1, 1'b1);
      link.frm[121] = ~link.frm[121];
      run(130, 1'b1, 1'b0);
      // Pattern mode that also needs the wake-up pattern
      @(posedge clk);
      ecs <= csum(0, 64'h0);
      ctl <= 16'h0700;
      run(130, 1'b1, 1'b0);
      link.frm[121] = ~link.frm[121];
      run(130, 1'b1, 1'b1);
   endtask : t_wake

   task automatic t_pattern;
      build(48'h0a0b_0c0d_0e0f);
      @(posedge clk);
      ctl <= 16'h0100;
      mask <= 64'h0000_0000_0000_00f5;
      ecs <= csum(0, 64'hf5);
      run(64, 1'b1, 1'b1);
      run(63, 1'b1, 1'b0);
      @(posedge clk);
      ctl <= 16'h1100;
      run(64, 1'b1, 1'b0);
      @(posedge clk);
      ctl <= 16'h0100;
      offs <= 16'h0006;
      ecs <= csum(6, 64'hf5);
      run(69, 1'b1, 1'b0);
      run(70, 1'b1, 1'b1);
      @(posedge clk);
      ctl <= 16'h0500;
      run(70, 1'b1, 1'b0);
      build(48'hffff_ffff_ffff);
      run(70, 1'b1, 1'b1);
   endtask : t_pattern

   // Hash filter, remaining pattern modes and broadcast enable
   task automatic t_hash;
      build(48'h0100_0000_012c);
      @(posedge clk);
      ctl <= 16'h8000;
      ht <= 64'h0010_0000_0000_0000;
      run(70, 1'b1, 1'b1);
      @(posedge clk);
      ht <= 64'hffef_ffff_ffff_ffff;
      run(70, 1'b1, 1'b0);
      @(posedge clk);
      ctl <= 16'h0600;
      run(70, 1'b1, 1'b0);
      @(posedge clk);
      ht <= 64'h0010_0000_0000_0000;
      run(70, 1'b1, 1'b1);
      @(posedge clk);
      ctl <= 16'h0400;
      run(70, 1'b1, 1'b1);
      @(posedge clk);
      ctl <= 16'h0300;
      run(70, 1'b1, 1'b0);
      build(48'h0a0b_0c0d_0e0f);
      run(70, 1'b1, 1'b1);
      @(posedge clk);
      ctl <= 16'h0200;
      run(70, 1'b1, 1'b0);
      build(sta);
      run(70, 1'b1, 1'b1);
      build(48'hffff_ffff_ffff);
      @(posedge clk);
      ctl <= 16'h0001;
      run(70, 1'b1, 1'b1);
   endtask : t_hash

   task automatic t_promisc;
      @(posedge clk);
      ctl <= 16'h005e;
      build(sta);
      run(64, 1'b1, 1'b1);
      build(48'h0300_0000_0001);
      run(64, 1'b1, 1'b1);
      @(posedge clk);
      free <= 16'h0000;
      run(64, 1'b1, 1'b0);
      @(posedge clk);
      free <= 16'h0040;
      mac1 <= 16'h0002;
      run(20, 1'b0, 1'b1);
      @(posedge clk);
      mac1 <= 16'h0000;
      run(20, 1'b0, 1'b0);
      while (exp_cnt != 8'hff) begin
         run(64, 1'b1, 1'b1);
      end
      run(64, 1'b1, 1'b0);
      @(posedge clk);
      cons <= 1'b1;
      repeat (3) @(posedge clk);
      cons <= 1'b0;
      @(posedge clk);
      #1;
      chk({8'h00, pending_packet_count_q}, 16'h00fc);
   endtask : t_promisc

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_wake();
      t_pattern();
      t_hash();
      t_promisc();
      results();
   end

   // Watchdog
   initial begin
      #250000;
      err_count++;
      results();
   end
endmodule : tb
